// [hw/uaar_match.sv]
// address comparator of one serial port
// assumes all inputs come from logic on the same clock; purely combinational
`default_nettype none
module uaar_match
	import uaar_pkg::*;
(
	input wire logic [7:0] own,
	input wire logic [7:0] mask,
	input wire logic [7:0] addr,
	output logic match
);
	logic [7:0] given;
	logic [7:0] bcast;
	logic given_hit;
	logic bcast_hit;

	always_comb
	begin
		given = own & mask;
		bcast = own | mask;
		// given positions compared only where mask is one
		given_hit = ((addr ^ given) & mask) == 8'h00;
		// zero bits of the broadcast value are don't-care
		bcast_hit = ((addr ^ bcast) & bcast) == 8'h00;
		match = given_hit | bcast_hit;
	end
endmodule : uaar_match
`default_nettype wire

// [hw/uaar_top.sv]
// address recognition for two serial receivers, with an AXI4-Lite register slave
// assumes the frame shifter delivers each frame as a one-cycle pulse on this clock
//
// Chosen here: register access over AXI4-Lite.
`include "uaar_params.svh"
`default_nettype none
module uaar_top
	import uaar_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic [1:0] RX_FRAME_VALID,
	input wire logic [1:0][7:0] RX_FRAME_DATA,
	input wire logic [1:0] RX_FRAME_BIT9,
	output logic [1:0] RX_DONE,
	output logic [1:0] RX_ACCEPT
);
	localparam uaar_state_t RST_STATE = '{
		own: {`UAAR_RST_ADDR, `UAAR_RST_ADDR},
		mask: {`UAAR_RST_MASK, `UAAR_RST_MASK},
		ctl: {`UAAR_RST_CTL, `UAAR_RST_CTL},
		done: 2'h0,
		accept: 2'h0,
		rxbyte: 16'h0000,
		aw_got: 1'b0,
		awaddr: 12'h000,
		w_got: 1'b0,
		wbyte: 8'h00,
		wlane0: 1'b0,
		awready: 1'b0,
		wready: 1'b0,
		wst: UAAR_WS_IDLE,
		bvalid: 1'b0,
		bresp: `UAAR_RESP_OKAY,
		arready: 1'b0,
		rvalid: 1'b0,
		rdata: 32'h00000000,
		rresp: `UAAR_RESP_OKAY
	};

	logic rst_meta_n_r;
	logic rst_n_r;
	uaar_state_t s_r;
	uaar_state_t s_nxt;
	logic [1:0] hit;

	function automatic logic [11:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'b00, idx, 2'b00};
	endfunction : byte_addr

	function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
		addr_is = addr == byte_addr(idx);
	endfunction : addr_is

	// reset released through two flops so removal meets timing
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			rst_meta_n_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_n_r <= 1'b1;
			rst_n_r <= rst_meta_n_r;
		end
	end

	// one comparator per port, each with its own register pair
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_port
			uaar_match u_match (
				.own(s_r.own[gi]),
				.mask(s_r.mask[gi]),
				.addr(RX_FRAME_DATA[gi]),
				.match(hit[gi])
			);
		end
	endgenerate

	always_comb
	begin
		logic [1:0] set_done;
		logic [1:0] clr_done;
		logic wr_ok;
		set_done = 2'b00;
		clr_done = 2'b00;
		wr_ok = 1'b0;
		s_nxt = s_r;
		s_nxt.accept = 2'b00;

		// frame qualification per port
		for (int i = 0; i < 2; i++)
		begin
			if (RX_FRAME_VALID[i])
			begin
				if (!s_r.ctl[i].enable)
					set_done[i] = 1'b1;
				else if (s_r.ctl[i].mode == `UAAR_MODE_SHIFT)
					set_done[i] = 1'b1;
				else if (s_r.ctl[i].mode == `UAAR_MODE_ASYNC8)
					set_done[i] = RX_FRAME_BIT9[i] & hit[i];
				else
					// ninth bit zero marks a data byte, which is dropped here
					set_done[i] = RX_FRAME_BIT9[i] & hit[i];
			end
			if (set_done[i])
				s_nxt.rxbyte[i] = RX_FRAME_DATA[i];
		end
		s_nxt.accept = set_done;

		// write channel: address and data taken in either order
		if (S_AXI_AWVALID && s_r.awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s_r.wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wbyte = S_AXI_WDATA[7:0];
			s_nxt.wlane0 = S_AXI_WSTRB[0];
		end

		case (s_r.wst)
			UAAR_WS_IDLE:
			begin
				if (s_r.aw_got && s_r.w_got)
				begin
					wr_ok = 1'b1;
					s_nxt.bresp = `UAAR_RESP_OKAY;
					if (addr_is(s_r.awaddr, `UAAR_IDX_OWN0))
					begin
						if (s_r.wlane0)
							s_nxt.own[0] = s_r.wbyte;
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_MASK0))
					begin
						if (s_r.wlane0)
							s_nxt.mask[0] = s_r.wbyte;
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_MASK1))
					begin
						if (s_r.wlane0)
							s_nxt.mask[1] = s_r.wbyte;
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_OWN1))
					begin
						if (s_r.wlane0)
							s_nxt.own[1] = s_r.wbyte;
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_CTL0))
					begin
						if (s_r.wlane0)
							s_nxt.ctl[0] = s_r.wbyte[`UAAR_CTL_MODE_LSB+1:`UAAR_CTL_EN_BIT];
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_CTL1))
					begin
						if (s_r.wlane0)
							s_nxt.ctl[1] = s_r.wbyte[`UAAR_CTL_MODE_LSB+1:`UAAR_CTL_EN_BIT];
					end
					else if (addr_is(s_r.awaddr, `UAAR_IDX_STAT))
					begin
						if (s_r.wlane0)
							clr_done = s_r.wbyte[`UAAR_STAT_DONE_LSB+1:`UAAR_STAT_DONE_LSB];
					end
					else
						s_nxt.bresp = `UAAR_RESP_SLVERR;
					s_nxt.wst = UAAR_WS_RESP;
					s_nxt.bvalid = 1'b1;
				end
			end
			UAAR_WS_RESP:
			begin
				if (S_AXI_BREADY)
				begin
					s_nxt.bvalid = 1'b0;
					s_nxt.aw_got = 1'b0;
					s_nxt.w_got = 1'b0;
					s_nxt.wst = UAAR_WS_IDLE;
				end
			end
			default:
				s_nxt.wst = UAAR_WS_IDLE;
		endcase

		// write-one-to-clear; a frame in the same cycle keeps its flag
		s_nxt.done = (s_r.done & ~clr_done) | set_done;

		s_nxt.awready = !s_nxt.aw_got && !wr_ok && s_nxt.wst == UAAR_WS_IDLE;
		s_nxt.wready = !s_nxt.w_got && !wr_ok && s_nxt.wst == UAAR_WS_IDLE;

		// read channel: one read at a time, answer one cycle after acceptance
		if (s_r.rvalid && S_AXI_RREADY)
			s_nxt.rvalid = 1'b0;
		if (S_AXI_ARVALID && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `UAAR_RESP_OKAY;
			s_nxt.rdata = 32'h00000000;
			if (addr_is(S_AXI_ARADDR, `UAAR_IDX_OWN0))
				s_nxt.rdata[7:0] = s_r.own[0];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_MASK0))
				s_nxt.rdata[7:0] = s_r.mask[0];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_MASK1))
				s_nxt.rdata[7:0] = s_r.mask[1];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_OWN1))
				s_nxt.rdata[7:0] = s_r.own[1];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_CTL0))
				s_nxt.rdata[2:0] = s_r.ctl[0];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_CTL1))
				s_nxt.rdata[2:0] = s_r.ctl[1];
			else if (addr_is(S_AXI_ARADDR, `UAAR_IDX_STAT))
			begin
				s_nxt.rdata[`UAAR_STAT_DONE_LSB+1:`UAAR_STAT_DONE_LSB] = s_r.done;
				s_nxt.rdata[`UAAR_STAT_BYTE0_LSB+7:`UAAR_STAT_BYTE0_LSB] = s_r.rxbyte[0];
				s_nxt.rdata[`UAAR_STAT_BYTE1_LSB+7:`UAAR_STAT_BYTE1_LSB] = s_r.rxbyte[1];
			end
			else
				s_nxt.rresp = `UAAR_RESP_SLVERR;
		end
		s_nxt.arready = !s_nxt.rvalid;
	end

	// reset clears both address pairs, so all addresses pass
	always_ff @(posedge CLOCK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			s_r <= RST_STATE;
		else
			s_r <= s_nxt;
	end

	assign S_AXI_AWREADY = s_r.awready;
	assign S_AXI_WREADY = s_r.wready;
	assign S_AXI_BVALID = s_r.bvalid;
	assign S_AXI_BRESP = s_r.bresp;
	assign S_AXI_ARREADY = s_r.arready;
	assign S_AXI_RVALID = s_r.rvalid;
	assign S_AXI_RDATA = s_r.rdata;
	assign S_AXI_RRESP = s_r.rresp;
	assign RX_DONE = s_r.done;
	assign RX_ACCEPT = s_r.accept;
endmodule : uaar_top
`default_nettype wire

// [include/uaar_params.svh]
// constants of the uart address recognition block: register indices, fields, resets
// assumes byte address of a register is four times its index on the register bus
// Behaviour
// - receive-complete flag set for an address frame only when hardware comparison accepts it
// - address filtering active while multiproc_enable is set, except in shift mode, where every frame raises the flag
// - 8-bit async mode with filtering: stop bit acts as ninth bit, needs match too
// - given address is own address AND mask; zero mask bits are don't-care
// - broadcast address is own address OR mask; zero result bits are don't-care
// - own address and mask registers reset to zero, so every address is accepted
// - two independent 8-bit own-address and mask pairs, one per serial port
// - 9-bit modes with filtering: only frames with ninth bit one raise the flag
`ifndef UAAR_PARAMS_SVH
`define UAAR_PARAMS_SVH

`define UAAR_IDX_OWN0 8'hA9
`define UAAR_IDX_MASK0 8'hB9
`define UAAR_IDX_MASK1 8'hBA
`define UAAR_IDX_OWN1 8'hBB
`define UAAR_IDX_CTL0 8'hC0
`define UAAR_IDX_CTL1 8'hC1
`define UAAR_IDX_STAT 8'hC2

`define UAAR_CTL_EN_BIT 0
`define UAAR_CTL_MODE_LSB 1
`define UAAR_STAT_DONE_LSB 0
`define UAAR_STAT_BYTE0_LSB 8
`define UAAR_STAT_BYTE1_LSB 16

`define UAAR_RST_ADDR 8'h00
`define UAAR_RST_MASK 8'h00
`define UAAR_RST_CTL 3'h0

`define UAAR_MODE_SHIFT 2'h0
`define UAAR_MODE_ASYNC8 2'h1

`define UAAR_RESP_OKAY 2'h0
`define UAAR_RESP_SLVERR 2'h2

`endif

// [include/uaar_pkg.sv]
// types shared by the address recognition block
// assumes uaar_params.svh is on the include path
`default_nettype none
package uaar_pkg;
	typedef enum logic [1:0] {
		UAAR_WS_IDLE = 2'b01,
		UAAR_WS_RESP = 2'b10
	} uaar_wst_t;

	// field order gives enable bit 0 and mode bits 2:1, as the ctl word is laid out
	typedef struct packed {
		logic [1:0] mode;
		logic enable;
	} uaar_ctl_t;

	typedef struct packed {
		logic [1:0][7:0] own;
		logic [1:0][7:0] mask;
		uaar_ctl_t [1:0] ctl;
		logic [1:0] done;
		logic [1:0] accept;
		logic [1:0][7:0] rxbyte;
		logic aw_got;
		logic [11:0] awaddr;
		logic w_got;
		logic [7:0] wbyte;
		logic wlane0;
		logic awready;
		logic wready;
		uaar_wst_t wst;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} uaar_state_t;
endpackage : uaar_pkg
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench: bus master, frame stimulus, reference model
// assumes uaar_top, uaar_rmaster and a 100 ns clock
`include "uaar_params.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
	logic [11:0] aa;
	logic [3:0] ws;
	logic [31:0] wd, rd;
	logic [1:0] br, rr, rxv, b9, done, accp, dn, md[2];
	logic [1:0][7:0] rxd;
	logic [7:0] ow[2], mk[2], lb[2];
	logic [7:0] rl[6] = '{8'hA9, 8'hB9, 8'hBA, 8'hBB, 8'hC0, 8'hC1};
	logic en[2];
	int failures, n_compared;
	uaar_top uaar_top_inst (.CLOCK(clk), .NRST(nrst),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aa),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(aa),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
		.RX_FRAME_VALID(rxv), .RX_FRAME_DATA(rxd), .RX_FRAME_BIT9(b9),
		.RX_DONE(done), .RX_ACCEPT(accp));
	uaar_rmaster uaar_rmaster_inst (.clk(clk), .vld(rxv), .dat(rxd), .b9(b9));
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d,
		input logic [1:0] e);
		logic [4:0] t;
		int n;
		n = 0;
		t = 5'h00;
		awv <= w;
		wv <= w;
		arv <= !w;
		aa <= {2'h0, i, 2'h0};
		wd <= d;
		// ready raised late so the slave is seen holding its answer
		while (!(t[1] | t[0]))
		begin
			@(negedge clk);
			t = {awv & awr, wv & wr, arv & arr, bre & bv, rre & rv};
			if (t[1])
				chk(br, e);
			if (t[0])
				chk(rr, e);
			if (t[0])
				chk(rd, d);
			@(posedge clk);
			awv <= awv & !t[4];
			wv <= wv & !t[3];
			arv <= arv & !t[2];
			bre <= w & (n >= 3) & !t[1];
			rre <= !w & (n >= 3) & !t[0];
			n++;
		end
		// one idle edge, so the next call never reassigns a strobe in this step
		@(posedge clk);
	endtask : acc
	function automatic logic hit(input int p, input logic [7:0] a);
		logic [7:0] bc;
		bc = ow[p] | mk[p];
		return ((a & mk[p]) == (ow[p] & mk[p])) || ((a & bc) == bc);
	endfunction : hit
	task automatic fr(input int p, input logic [7:0] a, input logic n);
		logic x;
		x = !en[p] || md[p] == 2'h0 || (n && hit(p, a));
		uaar_rmaster_inst.send(p, a, n);
		if (x)
			dn[p] = 1'h1;
		if (x)
			lb[p] = a;
		@(negedge clk);
		chk(accp[p], x);
		chk(done, dn);
		@(posedge clk);
	endtask : fr
	task automatic cfg(input int p);
		logic [7:0] io;
		io = p ? `UAAR_IDX_OWN1 : `UAAR_IDX_OWN0;
		ow[p] = 8'($urandom);
		mk[p] = 8'($urandom);
		en[p] = 1'($urandom);
		md[p] = 2'($urandom);
		acc(1'h1, io, {24'h0, ow[p]}, 2'h0);
		acc(1'h1, p ? `UAAR_IDX_MASK1 : `UAAR_IDX_MASK0, {24'h0, mk[p]}, 2'h0);
		acc(1'h1, `UAAR_IDX_CTL0 + 8'(p), {29'h0, md[p], en[p]}, 2'h0);
		acc(1'h0, io, {24'h0, ow[p]}, 2'h0);
	endtask : cfg
	task automatic results;
		$display("failures %0d compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	initial
	begin
		#2000000;
		failures++;
		results;
	end
	initial
	begin
		int p;
		logic [7:0] a, r;
		{nrst, awv, wv, bre, arv, rre, aa, wd, dn} = '0;
		ws = 4'hF;
		failures = 0;
		n_compared = 0;
		for (int j = 0; j < 2; j++)
			{ow[j], mk[j], lb[j], en[j], md[j]} = '0;
		void'($urandom(32'h8F35E3AC));
		repeat (6) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		foreach (rl[j])
			acc(1'h0, rl[j], 32'h0, 2'h0);
		acc(1'h0, 8'h04, 32'h0, `UAAR_RESP_SLVERR);
		acc(1'h1, 8'h04, 32'hFF, `UAAR_RESP_SLVERR);
		// low lane strobe off: the write is answered but changes nothing
		ws <= 4'hE;
		acc(1'h1, `UAAR_IDX_OWN0, 32'hAA, 2'h0);
		ws <= 4'hF;
		acc(1'h0, `UAAR_IDX_OWN0, 32'h0, 2'h0);
		en[0] = 1'h1;
		md[0] = 2'h2;
		acc(1'h1, `UAAR_IDX_CTL0, 32'h5, 2'h0);
		fr(0, 8'h5A, 1'h1);
		for (int k = 0; k < 400; k++)
		begin
			if (k % 16 == 0)
				cfg(k / 16 % 2);
			p = $urandom % 2;
			r = 8'($urandom);
			case ($urandom % 4)
				0: a = r;
				1: a = (ow[p] & mk[p]) | (r & ~mk[p]);
				2: a = ow[p] | mk[p] | r;
				default: a = 8'hFF;
			endcase
			fr(p, a, 1'($urandom));
			if (k % 20 == 19)
			begin
				acc(1'h0, `UAAR_IDX_STAT, {8'h0, lb[1], lb[0], 6'h0, dn}, 2'h0);
				acc(1'h1, `UAAR_IDX_STAT, 32'h3, 2'h0);
				dn = 2'h0;
			end
		end
		results;
	end
endmodule : testbench
`default_nettype wire

// [verif/uaar_chk.sv]
// checker on the top-level ports of the address filter
// assumes it is bound onto uaar_top, single clock
`default_nettype none
module uaar_chk (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] RX_FRAME_VALID,
	input wire logic [1:0] RX_DONE,
	input wire logic [1:0] RX_ACCEPT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);
	sequence w_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence ar_taken;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	AST_ACC0: assert property (RX_ACCEPT[0] |-> $past(RX_FRAME_VALID[0]))
		else $error("accept0 without frame");
	AST_ACC1: assert property (RX_ACCEPT[1] |-> $past(RX_FRAME_VALID[1]))
		else $error("accept1 without frame");
	AST_DONE: assert property ($rose(RX_DONE[0]) |-> RX_ACCEPT[0])
		else $error("done0 rose unaccepted");
	AST_SET: assert property ((RX_ACCEPT & ~RX_DONE) == 2'h0)
		else $error("accept without done");
	AST_PULSE: assert property (RX_ACCEPT[1] && !RX_FRAME_VALID[1] |=> !RX_ACCEPT[1])
		else $error("accept1 too long");
	AST_BLAT: assert property (w_taken |-> ##[1:3] S_AXI_BVALID)
		else $error("no write response");
	AST_BHOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	AST_RLAT: assert property (ar_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read response late");
	AST_RHOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
		else $error("read data moved");
endmodule : uaar_chk
bind uaar_top uaar_chk uaar_chk_inst (.CLOCK, .NRST, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
	.S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .RX_FRAME_VALID,
	.RX_DONE, .RX_ACCEPT);
`default_nettype wire

// [verif/uaar_rmaster.sv]
// remote master model: sends address frames to the two receivers
// assumes send is called right after a rising clock edge
`default_nettype none
module uaar_rmaster (
	input wire logic clk,
	output logic [1:0] vld,
	output logic [1:0][7:0] dat,
	output logic [1:0] b9
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		vld = 2'h0;
		dat = 16'h0;
		b9 = 2'h0;
	end
	task automatic send(input int p, input logic [7:0] a, input logic n);
		vld[p] <= 1'h1;
		dat[p] <= a;
		b9[p] <= n;
		@(posedge clk);
		vld[p] <= 1'h0;
		// released lines must not keep showing the last byte
		dat[p] <= ~a;
		b9[p] <= ~n;
	endtask : send
endmodule : uaar_rmaster
`default_nettype wire
